// *** logic/cpbi_dev.sv ***
module cpbi_dev (
   // Clock and control
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic reset_in,
   // Link
   cpbi_if.dev bus,
   // Numeric core side
   input wire logic xfer_req,
   input wire logic xfer_write,
   input wire logic [19:0] xfer_addr,
   input wire logic [15:0] xfer_wdata,
   input wire logic xfer_byte_high,
   input wire logic xfer_wide_bus,
   input wire logic [7:0] exec_length,
   input wire logic exec_fault,
   output logic xfer_done,
   output logic [15:0] xfer_rdata,
   output logic [7:0] opcode,
   output logic opcode_valid,
   output logic host_cycle_seen
);
   // ----------------------------------------
   // Reset qualification
   // ----------------------------------------
   logic [1:0] reset_cnt;
   logic core_reset;
   logic rg0_in;
   logic rg1_in;
   cpbi_pkg::cpbi_arb_t arb;
   cpbi_pkg::cpbi_bc_t bc;
   logic start_exec;
   logic exec_busy;
   logic exec_done;
   logic exec_error;
   logic pending;

   // Reset pin must stand four clocks before it counts
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reset_cnt <= cpbi_pkg::RESET_CNT_INIT;
         core_reset <= 1'b1;
      end else if (clk_en) begin
         if (!reset_in) begin
            reset_cnt <= cpbi_pkg::RESET_CNT_INIT;
            core_reset <= 1'b0;
         end else if (reset_cnt == cpbi_pkg::RESET_CNT_DONE) begin
            core_reset <= 1'b1;
         end else begin
            reset_cnt <= reset_cnt + 2'h1;
         end
      end
   end

   // A pulse is a low level on a line while the far end enables it
   assign rg0_in = bus.rg0_host_oe && !bus.rg0_host_o;
   assign rg1_in = bus.rg1_host_oe && !bus.rg1_host_o;

   // ----------------------------------------
   // Instruction stream tracking
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n || core_reset) begin
         opcode <= 8'h00;
         opcode_valid <= 1'b0;
         host_cycle_seen <= 1'b0;
         start_exec <= 1'b0;
      end else if (clk_en) begin
         opcode_valid <= 1'b0;
         start_exec <= 1'b0;
         // Low status six marks the host as current master
         host_cycle_seen <= !bus.upper_host[3];
         if (bus.queue_state == cpbi_pkg::QS_FIRST) begin
            opcode <= bus.ad_host[7:0];
            opcode_valid <= 1'b1;
            // Escape opcodes have top five bits 11011
            start_exec <= (bus.ad_host[7:3] == 5'h1b) && !exec_busy;
         end
      end
   end

   cpbi_exec cpbi_exec_inst (
      .core_clk(core_clk),
      .rst_n(rst_n && !core_reset),
      .clk_en(clk_en),
      .start(start_exec),
      .length(exec_length),
      .fault(exec_fault),
      .busy(exec_busy),
      .done(exec_done),
      .error(exec_error)
   );

   always_ff @(posedge core_clk) begin
      if (!rst_n || core_reset) begin
         bus.busy <= 1'b0;
         bus.int_req <= 1'b0;
      end else if (clk_en) begin
         bus.busy <= exec_busy || start_exec;
         if (exec_done && exec_error) begin
            bus.int_req <= 1'b1;
         end else if (start_exec) begin
            bus.int_req <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Bus arbitration
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n || core_reset) begin
         arb <= cpbi_pkg::ARB_IDLE;
         pending <= 1'b0;
         bus.rg0_dev_o <= 1'b1;
         bus.rg0_dev_oe <= 1'b0;
         bus.rg1_dev_o <= 1'b1;
         bus.rg1_dev_oe <= 1'b0;
      end else if (clk_en) begin
         bus.rg0_dev_o <= 1'b1;
         bus.rg0_dev_oe <= 1'b0;
         bus.rg1_dev_o <= 1'b1;
         bus.rg1_dev_oe <= 1'b0;
         if (xfer_req && bc == cpbi_pkg::BC_IDLE) begin
            pending <= 1'b1;
         end
         unique case (arb)
            cpbi_pkg::ARB_IDLE: begin
               if (rg1_in) begin
                  // Relay secondary request to host
                  bus.rg0_dev_o <= 1'b0;
                  bus.rg0_dev_oe <= 1'b1;
                  arb <= cpbi_pkg::ARB_RELAY;
               end else if (pending || xfer_req) begin
                  bus.rg0_dev_o <= 1'b0;
                  bus.rg0_dev_oe <= 1'b1;
                  arb <= cpbi_pkg::ARB_REQ;
               end
            end
            cpbi_pkg::ARB_REQ: begin
               if (rg0_in) begin
                  arb <= cpbi_pkg::ARB_OWN;
               end
            end
            cpbi_pkg::ARB_OWN: begin
               if (rg1_in) begin
                  // Secondary wins: grant directly, keep host out
                  bus.rg1_dev_o <= 1'b0;
                  bus.rg1_dev_oe <= 1'b1;
                  arb <= cpbi_pkg::ARB_SECOND;
               end else if (!pending && bc == cpbi_pkg::BC_IDLE) begin
                  bus.rg0_dev_o <= 1'b0;
                  bus.rg0_dev_oe <= 1'b1;
                  arb <= cpbi_pkg::ARB_IDLE;
               end
            end
            cpbi_pkg::ARB_SECOND: begin
               if (rg1_in) begin
                  arb <= cpbi_pkg::ARB_OWN; // back to device
               end
            end
            cpbi_pkg::ARB_RELAY: begin
               // Pass grant and release pulses across
               if (rg0_in) begin
                  bus.rg1_dev_o <= 1'b0;
                  bus.rg1_dev_oe <= 1'b1;
               end else if (rg1_in) begin
                  bus.rg0_dev_o <= 1'b0;
                  bus.rg0_dev_oe <= 1'b1;
                  arb <= cpbi_pkg::ARB_IDLE;
               end
            end
            default: arb <= cpbi_pkg::ARB_IDLE;
         endcase
         if (bc == cpbi_pkg::BC_END) begin
            pending <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Own bus cycles
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n || core_reset) begin
         bc <= cpbi_pkg::BC_IDLE;
         bus.ad_dev <= 16'h0000;
         bus.ad_dev_oe <= 1'b0;
         bus.upper_dev <= 4'h0;
         bus.upper_dev_oe <= 1'b0;
         bus.bhe_dev <= 1'b1;
         bus.cyc_dev <= cpbi_pkg::CYC_PASSIVE;
         bus.cyc_dev_oe <= 1'b1;
         xfer_done <= 1'b0;
         xfer_rdata <= 16'h0000;
      end else if (clk_en) begin
         xfer_done <= 1'b0;
         unique case (bc)
            cpbi_pkg::BC_IDLE: begin
               bus.cyc_dev <= cpbi_pkg::CYC_PASSIVE;
               bus.cyc_dev_oe <= (arb == cpbi_pkg::ARB_OWN);
               bus.ad_dev_oe <= 1'b0;
               bus.upper_dev_oe <= 1'b0;
               // A secondary request in flight wins over a new cycle of our own
               if (arb == cpbi_pkg::ARB_OWN && pending && !rg1_in) begin
                  bus.cyc_dev <= xfer_write ? cpbi_pkg::CYC_WRITE : cpbi_pkg::CYC_READ;
                  bus.cyc_dev_oe <= 1'b1;
                  bus.ad_dev <= xfer_addr[15:0];
                  bus.ad_dev_oe <= 1'b1;
                  bus.upper_dev <= xfer_addr[19:16];
                  bus.upper_dev_oe <= 1'b1;
                  bus.bhe_dev <= !xfer_byte_high;
                  bc <= cpbi_pkg::BC_ADDR;
               end
            end
            cpbi_pkg::BC_ADDR: begin
               bus.upper_dev <= cpbi_pkg::UPPER_STATUS_OWN;
               // Status seven carries the byte high enable value
               bus.bhe_dev <= bus.bhe_dev;
               bus.cyc_dev <= cpbi_pkg::CYC_PASSIVE;
               if (xfer_write) begin
                  bus.ad_dev <= xfer_wide_bus ? xfer_wdata : {8'h00, xfer_wdata[7:0]};
               end else begin
                  bus.ad_dev_oe <= 1'b0;
               end
               bc <= cpbi_pkg::BC_DATA;
            end
            cpbi_pkg::BC_DATA: begin
               if (!xfer_write) begin
                  xfer_rdata <= xfer_wide_bus ? bus.ad_host : {8'h00, bus.ad_host[7:0]};
               end
               bus.ad_dev_oe <= 1'b0;
               xfer_done <= 1'b1;
               bc <= cpbi_pkg::BC_END;
            end
            cpbi_pkg::BC_END: begin
               bus.upper_dev_oe <= 1'b0;
               bus.bhe_dev <= 1'b1;
               bc <= cpbi_pkg::BC_IDLE;
            end
         endcase
      end
   end
endmodule

// *** logic/cpbi_pkg.sv ***
package cpbi_pkg;
   // ----------------------------------------
   // Cycle type codes, highest bit first
   // ----------------------------------------
   localparam logic [2:0] CYC_READ = 3'h5;
   localparam logic [2:0] CYC_WRITE = 3'h6;
   localparam logic [2:0] CYC_PASSIVE = 3'h7;
   // Upper status bits 3,4,5,6 in own cycles
   localparam logic [3:0] UPPER_STATUS_OWN = 4'hb;
   // Queue state codes
   localparam logic [1:0] QS_IDLE = 2'h0;
   localparam logic [1:0] QS_FIRST = 2'h1;
   localparam logic [1:0] QS_FLUSH = 2'h2;
   localparam logic [1:0] QS_NEXT = 2'h3;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int RESET_MIN_CYCLES = 4;
   localparam logic [1:0] RESET_CNT_INIT = 2'h0;
   localparam logic [1:0] RESET_CNT_DONE = 2'h3;
   localparam logic [7:0] EXEC_CNT_INIT = 8'h00;
   // ----------------------------------------
   // Bus arbitration states (Gray path)
   // ----------------------------------------
   typedef enum logic [2:0] {
      ARB_IDLE = 3'b000,
      ARB_REQ = 3'b001,
      ARB_OWN = 3'b011,
      ARB_RELAY = 3'b010,
      ARB_SECOND = 3'b110
   } cpbi_arb_t;
   // Bus cycle phases: address, data, done
   typedef enum logic [1:0] {
      BC_IDLE = 2'b00,
      BC_ADDR = 2'b01,
      BC_DATA = 2'b11,
      BC_END = 2'b10
   } cpbi_bc_t;
endpackage

// *** logic/cpbi_if.sv ***
interface cpbi_if;
   // Multiplexed address/data and status pins (three-signal form except BHE and queue state)
   logic [15:0] ad_host;
   logic [15:0] ad_dev;
   logic ad_dev_oe;
   logic [3:0] upper_host;
   logic [3:0] upper_dev;
   logic upper_dev_oe;
   logic bhe_host;
   logic bhe_dev;
   logic [2:0] cyc_host;
   logic [2:0] cyc_dev;
   logic cyc_dev_oe;
   logic [1:0] queue_state;
   // Request/grant lines, driven low as one-clock pulses
   logic rg0_host_o;
   logic rg0_host_oe;
   logic rg0_dev_o;
   logic rg0_dev_oe;
   logic rg1_dev_o;
   logic rg1_dev_oe;
   logic rg1_host_o;
   logic rg1_host_oe;
   logic busy;
   logic int_req;
   modport dev (
      input ad_host, upper_host, bhe_host, cyc_host, queue_state, rg0_host_o, rg0_host_oe,
      input rg1_host_o, rg1_host_oe,
      output ad_dev, ad_dev_oe, upper_dev, upper_dev_oe, bhe_dev, cyc_dev, cyc_dev_oe,
      output rg0_dev_o, rg0_dev_oe, rg1_dev_o, rg1_dev_oe, busy, int_req
   );
   modport host (
      output ad_host, upper_host, bhe_host, cyc_host, queue_state, rg0_host_o, rg0_host_oe,
      output rg1_host_o, rg1_host_oe,
      input ad_dev, ad_dev_oe, upper_dev, upper_dev_oe, bhe_dev, cyc_dev, cyc_dev_oe,
      input rg0_dev_o, rg0_dev_oe, rg1_dev_o, rg1_dev_oe, busy, int_req
   );
endinterface

// *** logic/cpbi_exec.sv ***
module cpbi_exec (
   // Clock and control
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Operation
   input wire logic start,
   input wire logic [7:0] length,
   input wire logic fault,
   output logic busy,
   output logic done,
   output logic error
);
   logic [7:0] count;

   // Runs on its own once started; host is free meanwhile
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         busy <= 1'b0;
         count <= cpbi_pkg::EXEC_CNT_INIT;
         done <= 1'b0;
         error <= 1'b0;
      end else if (clk_en) begin
         done <= 1'b0;
         if (!busy && start) begin
            busy <= 1'b1;
            count <= length;
            error <= 1'b0;
         end else if (busy) begin
            if (fault) begin
               error <= 1'b1;
            end
            if (count == cpbi_pkg::EXEC_CNT_INIT) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               count <= count - 8'h01;
            end
         end
      end
   end
endmodule

// *** logic/cpbi_host.sv ***
module cpbi_host (
   // Clock and control
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Link
   cpbi_if.host bus,
   // User side
   input wire logic [15:0] drive_ad,
   input wire logic [3:0] drive_upper,
   input wire logic drive_bhe,
   input wire logic [2:0] drive_cyc,
   input wire logic [1:0] drive_queue,
   input wire logic grant_enable,
   input wire logic second_request,
   input wire logic second_release,
   output logic dev_busy,
   output logic dev_int,
   output logic dev_owns_bus,
   output logic second_granted
);
   logic rg0_in;
   logic rg1_in;
   logic dev_req_held;
   assign rg0_in = bus.rg0_dev_oe && !bus.rg0_dev_o;
   assign rg1_in = bus.rg1_dev_oe && !bus.rg1_dev_o;

   // ----------------------------------------
   // Bus drive from user inputs, also while the device owns it
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bus.ad_host <= 16'h0000;
         bus.upper_host <= 4'h0;
         bus.bhe_host <= 1'b1;
         bus.cyc_host <= cpbi_pkg::CYC_PASSIVE;
         bus.queue_state <= cpbi_pkg::QS_IDLE;
      end else if (clk_en) begin
         bus.ad_host <= drive_ad;
         // Only the host may show status six low
         bus.upper_host <= drive_upper;
         bus.bhe_host <= drive_bhe;
         bus.cyc_host <= drive_cyc;
         bus.queue_state <= drive_queue;
      end
   end

   // ----------------------------------------
   // Handshake: grant device, model secondary master
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dev_owns_bus <= 1'b0;
         dev_req_held <= 1'b0;
         second_granted <= 1'b0;
         bus.rg0_host_o <= 1'b1;
         bus.rg0_host_oe <= 1'b0;
         bus.rg1_host_o <= 1'b1;
         bus.rg1_host_oe <= 1'b0;
         dev_busy <= 1'b0;
         dev_int <= 1'b0;
      end else if (clk_en) begin
         dev_busy <= bus.busy;
         dev_int <= bus.int_req;
         bus.rg0_host_o <= 1'b1;
         bus.rg0_host_oe <= 1'b0;
         bus.rg1_host_o <= 1'b1;
         bus.rg1_host_oe <= 1'b0;
         if (rg0_in && dev_owns_bus) begin
            dev_owns_bus <= 1'b0;
         end else if (rg0_in || dev_req_held) begin
            if (grant_enable) begin
               // Grant withheld until grant_enable is set
               bus.rg0_host_o <= 1'b0;
               bus.rg0_host_oe <= 1'b1;
               dev_owns_bus <= 1'b1;
               dev_req_held <= 1'b0;
            end else begin
               // The request pulse is one clock long, so it must be remembered
               dev_req_held <= 1'b1;
            end
         end
         if (rg1_in) begin
            second_granted <= 1'b1;
         end
         if ((second_request && !second_granted) || (second_release && second_granted)) begin
            bus.rg1_host_o <= 1'b0;
            bus.rg1_host_oe <= 1'b1;
            if (second_release) begin
               second_granted <= 1'b0;
            end
         end
      end
   end
endmodule

// *** test/cpbi_sva.sv ***
module cpbi_sva (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Device side of the link
   input wire logic ad_dev_oe,
   input wire logic [3:0] upper_dev,
   input wire logic upper_dev_oe,
   input wire logic bhe_dev,
   input wire logic [2:0] cyc_dev,
   input wire logic cyc_dev_oe,
   input wire logic rg0_dev_o,
   input wire logic rg0_dev_oe,
   input wire logic rg1_dev_o,
   input wire logic rg1_dev_oe,
   input wire logic busy,
   input wire logic int_req
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ------------------------------
   // Bus cycle phases
   // ------------------------------
   sequence addr_phase;
      $rose(upper_dev_oe) && ad_dev_oe;
   endsequence
   sequence data_phase;
      upper_dev_oe && upper_dev == cpbi_pkg::UPPER_STATUS_OWN;
   endsequence
   a_addr_on_ad: assert property ($rose(upper_dev_oe) |-> ad_dev_oe)
      else $error("address phase without AD drive");
   a_upper_status_own: assert property (addr_phase |=> data_phase)
      else $error("upper status wrong in data phase");
   a_bhe_held: assert property (addr_phase |=> $stable(bhe_dev))
      else $error("byte high enable moved within cycle");
   a_cycle_code: assert property (cyc_dev_oe |-> cyc_dev inside {3'h5, 3'h6, 3'h7})
      else $error("unused cycle code driven");
   // Three idle cycles leave room for the done phase to finish
   a_passive_idle: assert property ((!upper_dev_oe)[*3] |-> cyc_dev == 3'h7)
      else $error("no passive code while idle");
   a_rg0_pulse: assert property (rg0_dev_oe |-> !rg0_dev_o ##1 !rg0_dev_oe)
      else $error("host handshake pulse not single low clock");
   a_rg1_pulse: assert property (rg1_dev_oe |-> !rg1_dev_o ##1 !rg1_dev_oe)
      else $error("secondary handshake pulse not single low clock");
   a_busy_min_hold: assert property ($rose(busy) |-> busy[*2])
      else $error("busy shorter than two cycles");
   a_int_at_end: assert property ($rose(int_req) |-> busy || $past(busy) || $past(busy, 2))
      else $error("interrupt without execution");
endmodule

// *** test/cpbi_bench.sv ***
module cpbi_bench;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
`define WAIT(c) begin for (int w = 0; w < 50 && !(c); w++) @(negedge core_clk); \
   if (!(c)) n_errors++; end
   logic core_clk, rst_n, reset_in, xfer_req, xfer_write, xfer_byte_high, xfer_wide_bus;
   logic exec_fault, xfer_done, opcode_valid, host_cycle_seen, drive_bhe, grant_enable;
   logic second_request, second_release, dev_busy, dev_int, dev_owns_bus, second_granted;
   logic [19:0] xfer_addr;
   logic [15:0] xfer_wdata, xfer_rdata, drive_ad;
   logic [7:0] exec_length, opcode;
   logic [3:0] drive_upper;
   logic [2:0] drive_cyc;
   logic [1:0] drive_queue;
   int n_errors, total_checks;
   cpbi_if link();
   cpbi_dev cpbi_dev_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
      .reset_in(reset_in), .bus(link), .xfer_req(xfer_req), .xfer_write(xfer_write),
      .xfer_addr(xfer_addr), .xfer_wdata(xfer_wdata), .xfer_byte_high(xfer_byte_high),
      .xfer_wide_bus(xfer_wide_bus), .exec_length(exec_length), .exec_fault(exec_fault),
      .xfer_done(xfer_done), .xfer_rdata(xfer_rdata), .opcode(opcode),
      .opcode_valid(opcode_valid), .host_cycle_seen(host_cycle_seen));
   cpbi_host cpbi_host_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .bus(link),
      .drive_ad(drive_ad), .drive_upper(drive_upper), .drive_bhe(drive_bhe),
      .drive_cyc(drive_cyc), .drive_queue(drive_queue), .grant_enable(grant_enable),
      .second_request(second_request), .second_release(second_release),
      .dev_busy(dev_busy), .dev_int(dev_int), .dev_owns_bus(dev_owns_bus),
      .second_granted(second_granted));
   cpbi_sva cpbi_sva_inst (.core_clk(core_clk), .rst_n(rst_n), .ad_dev_oe(link.ad_dev_oe),
      .upper_dev(link.upper_dev), .upper_dev_oe(link.upper_dev_oe), .bhe_dev(link.bhe_dev),
      .cyc_dev(link.cyc_dev), .cyc_dev_oe(link.cyc_dev_oe), .rg0_dev_o(link.rg0_dev_o),
      .rg0_dev_oe(link.rg0_dev_oe), .rg1_dev_o(link.rg1_dev_o),
      .rg1_dev_oe(link.rg1_dev_oe), .busy(link.busy), .int_req(link.int_req));
   initial begin
      core_clk = 1'b0;
      forever #(cpbi_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;
   end
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_identity;
      for (int i = 0; i < 2; i++) begin
         drive_upper = (i == 0) ? 4'h7 : 4'hf;
         repeat (4) @(negedge core_clk);
         `CHK(host_cycle_seen, (i == 0))
      end
   endtask
   // A second escape lands while link.busy is high; at nonzero length a wrong count shows it was taken
   task automatic t_escape(input logic [7:0] len, input logic flt);
      int n;
      exec_length = len;
      exec_fault = flt;
      drive_ad = 16'h00d9;
      drive_queue = cpbi_pkg::QS_FIRST;
      @(negedge core_clk);
      drive_queue = cpbi_pkg::QS_IDLE;
      `WAIT(link.busy === 1'b1)
      n = 0;
      while (link.busy === 1'b1 && n < 300) begin
         n++;
         drive_queue = (n == 1) ? cpbi_pkg::QS_FIRST : cpbi_pkg::QS_IDLE;
         @(negedge core_clk);
      end
      `CHK(n, int'(len) + 2)
      repeat (3) @(negedge core_clk);
      `CHK(link.int_req, flt)
      `CHK(dev_int, flt)
      `CHK(link.busy, 1'b0)
      `CHK(opcode, 8'hd9)
   endtask
   task automatic t_xfer(input logic w, input logic [19:0] a, input logic [15:0] d,
         input logic bh, input logic wide);
      logic [15:0] m;
      m = wide ? 16'hffff : 16'h00ff;
      xfer_write = w;
      xfer_addr = a;
      xfer_wdata = d;
      xfer_byte_high = bh;
      xfer_wide_bus = wide;
      // Host lines carry other data on writes so a copied bus is caught
      drive_ad = w ? ~d : d;
      xfer_req = 1'b1;
      `WAIT(link.upper_dev_oe === 1'b1)
      `CHK(link.cyc_dev, w ? cpbi_pkg::CYC_WRITE : cpbi_pkg::CYC_READ)
      `CHK(link.ad_dev, a[15:0])
      `CHK(link.upper_dev, a[19:16])
      @(negedge core_clk);
      `CHK(link.upper_dev, cpbi_pkg::UPPER_STATUS_OWN)
      `CHK(link.bhe_dev, !bh)
      `CHK(dev_owns_bus, 1'b1)
      if (w) `CHK(link.ad_dev & m, d & m)
      `WAIT(xfer_done === 1'b1)
      `CHK(xfer_done, 1'b1)
      if (!w) `CHK(xfer_rdata & m, d & m)
      xfer_req = 1'b0;
      `WAIT(dev_owns_bus === 1'b0)
      `CHK(link.cyc_dev, cpbi_pkg::CYC_PASSIVE)
   endtask
   task automatic t_hold;
      grant_enable = 1'b0;
      xfer_req = 1'b1;
      repeat (12) @(negedge core_clk);
      `CHK(link.upper_dev_oe, 1'b0)
      `CHK(dev_owns_bus, 1'b0)
      grant_enable = 1'b1;
      t_xfer(1'b0, 20'hf_0002, 16'h0ff0, 1'b1, 1'b1);
   endtask
   task automatic t_second;
      second_request = 1'b1;
      @(negedge core_clk);
      second_request = 1'b0;
      `WAIT(second_granted === 1'b1)
      `CHK(second_granted, 1'b1)
      `CHK(link.upper_dev_oe, 1'b0)
      second_release = 1'b1;
      @(negedge core_clk);
      second_release = 1'b0;
      `WAIT(second_granted === 1'b0)
      `CHK(second_granted, 1'b0)
      `WAIT(dev_owns_bus === 1'b0)
      `CHK(dev_owns_bus, 1'b0)
   endtask
   // Secondary asks while the device holds the bus: direct hand-over
   task automatic t_direct;
      xfer_write = 1'b0;
      xfer_req = 1'b1;
      `WAIT(dev_owns_bus === 1'b1)
      second_request = 1'b1;
      @(negedge core_clk);
      second_request = 1'b0;
      `WAIT(second_granted === 1'b1)
      `CHK(second_granted, 1'b1)
      `CHK(link.upper_dev_oe, 1'b0)
      `CHK(dev_owns_bus, 1'b1)
      second_release = 1'b1;
      @(negedge core_clk);
      second_release = 1'b0;
      `WAIT(xfer_done === 1'b1)
      `CHK(xfer_done, 1'b1)
      xfer_req = 1'b0;
      `WAIT(dev_owns_bus === 1'b0)
      `CHK(dev_owns_bus, 1'b0)
   endtask
   task automatic t_reset;
      exec_length = 8'hc8;
      drive_ad = 16'h00d9;
      drive_queue = cpbi_pkg::QS_FIRST;
      @(negedge core_clk);
      drive_queue = cpbi_pkg::QS_IDLE;
      repeat (6) @(negedge core_clk);
      `CHK(link.busy, 1'b1)
      reset_in = 1'b1;
      // Four clocks to qualify the pin, one more for the cleared state to show
      repeat (5) @(negedge core_clk);
      `CHK(link.busy, 1'b0)
      `CHK(link.cyc_dev, cpbi_pkg::CYC_PASSIVE)
      reset_in = 1'b0;
      repeat (3) @(negedge core_clk);
      `CHK(link.busy, 1'b0)
   endtask
   task print_verdict;
      $display("Checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #(cpbi_pkg::CLK_PERIOD_NS * 4000);
      n_errors++;
      print_verdict();
   end
   initial begin
      n_errors = 0;
      total_checks = 0;
      {rst_n, xfer_req, xfer_write, xfer_byte_high, xfer_wide_bus, exec_fault} = '0;
      {drive_bhe, second_request, second_release, xfer_addr, xfer_wdata, drive_ad} = '0;
      reset_in = 1'b1;
      grant_enable = 1'b1;
      exec_length = 8'h00;
      drive_upper = 4'hf;
      drive_cyc = cpbi_pkg::CYC_PASSIVE;
      drive_queue = cpbi_pkg::QS_IDLE;
      repeat (8) @(negedge core_clk);
      rst_n = 1'b1;
      reset_in = 1'b0;
      repeat (2) @(negedge core_clk);
      t_identity();
      t_escape(8'h03, 1'b1);
      t_escape(8'h00, 1'b0);
      t_xfer(1'b1, 20'h3_a5c4, 16'h1234, 1'b1, 1'b1);
      t_xfer(1'b0, 20'hc_0011, 16'h00e7, 1'b0, 1'b0);
      t_hold();
      t_second();
      t_direct();
      t_reset();
      print_verdict();
   end
endmodule
